// >>> sim/cdr_regfile_asserts.sv
// Port-level checker for the dedicated register file
`timescale 1ns/1ps
`default_nettype none

module cdr_regfile_asserts #(
    parameter logic [15:0] IO_TOP    = cdr_pkg::IO_TOP_DEF,
    parameter logic [15:0] PROG_BASE = cdr_pkg::PROG_BASE_DEF,
    parameter logic [15:0] GREG_BASE = cdr_pkg::GREG_BASE_DEF,
    parameter logic [15:0] VEC_TOP   = cdr_pkg::VEC_TOP_DEF
) (
    // Clock and reset
    input wire logic                      core_clk_i,
    input wire logic                      rst_i,
    // APB
    input wire logic                      psel_i,
    input wire logic                      penable_i,
    input wire logic                      pwrite_i,
    input wire logic [7:0]                paddr_i,
    input wire logic [31:0]               pwdata_i,
    input wire logic [31:0]               prdata_o,
    input wire logic                      pready_o,
    input wire logic                      pslverr_o,
    // Core side
    input wire logic                      fetch_step_i,
    input wire logic [5:0]                vector_num_i,
    input wire cdr_pkg::cdr_irq_s         irq_i,
    input wire logic [2:0]                greg_num_i,
    input wire logic [15:0]               instr_pointer_o,
    input wire cdr_pkg::cdr_status_word_s status_word_o,
    input wire logic                      irq_take_o,
    input wire logic [15:0]               greg_addr_o,
    input wire logic [15:0]               vector_addr_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    // Three idle edges so a one-cycle number override has surely expired
    sequence s_bus_quiet;
        !psel_i [*3];
    endsequence

    a_ready_after_setup: assert property (s_setup |=> pready_o)
        else $error("pready missing after setup");
    a_ready_one_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready held too long");
    a_rdata_idle_zero: assert property (!(pready_o && !pwrite_i) |-> prdata_o == 32'h0)
        else $error("read data not zero outside a read");
    a_err_decode: assert property (psel_i && !penable_i && paddr_i[1:0] == 2'h0
        |=> pslverr_o == ($past(paddr_i) > cdr_pkg::OFS_REGION_QUERY))
        else $error("slave error decode wrong");
    // Start only from an edge out of reset, outputs still hold reset values
    a_vector_addr: assert property (!rst_i
        |=> vector_addr_o == VEC_TOP - {$past(vector_num_i), 1'b0})
        else $error("vector address wrong");
    a_irq_take: assert property (!rst_i |=> irq_take_o == ($past(irq_i.req)
        && $past(status_word_o.flag_byte.irq_enable)
        && ($past(irq_i.level) < $past(status_word_o.flag_byte.priority_threshold))))
        else $error("interrupt acceptance wrong");
    a_greg_addr: assert property (s_bus_quiet |=> greg_addr_o == GREG_BASE
        + {$past(status_word_o.bank_select[4:0]), $past(greg_num_i, 2)})
        else $error("general register address wrong");
    a_ip_step: assert property (fetch_step_i && !psel_i
        |=> instr_pointer_o == $past(instr_pointer_o) + 16'h0001)
        else $error("instruction pointer did not step");
    a_ip_hold: assert property (!fetch_step_i && !(psel_i && penable_i && pwrite_i)
        |=> $stable(instr_pointer_o))
        else $error("instruction pointer moved");
endmodule

bind cdr_regfile cdr_regfile_asserts #(
    .IO_TOP(IO_TOP), .PROG_BASE(PROG_BASE), .GREG_BASE(GREG_BASE), .VEC_TOP(VEC_TOP)
) u_asserts (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .fetch_step_i(fetch_step_i),
    .vector_num_i(vector_num_i), .irq_i(irq_i), .greg_num_i(greg_num_i),
    .instr_pointer_o(instr_pointer_o), .status_word_o(status_word_o), .irq_take_o(irq_take_o),
    .greg_addr_o(greg_addr_o), .vector_addr_o(vector_addr_o)
);

`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the dedicated register file
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic                      core_clk_i;
    logic                      rst_i;
    logic                      psel_i;
    logic                      penable_i;
    logic                      pwrite_i;
    logic [7:0]                paddr_i;
    logic [31:0]               pwdata_i;
    logic [31:0]               prdata_o;
    logic                      pready_o;
    logic                      pslverr_o;
    logic                      fetch_step_i;
    logic [5:0]                vector_num_i;
    cdr_pkg::cdr_irq_s         irq_i;
    logic [2:0]                greg_num_i;
    logic [15:0]               instr_pointer_o;
    cdr_pkg::cdr_status_word_s status_word_o;
    logic                      irq_take_o;
    logic [15:0]               greg_addr_o;
    logic [15:0]               vector_addr_o;
    int                        bad_count;
    int                        check_count;
    logic [31:0]               rd;
    logic                      err;

    cdr_regfile DUT (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .fetch_step_i(fetch_step_i),
        .vector_num_i(vector_num_i), .irq_i(irq_i), .greg_num_i(greg_num_i),
        .instr_pointer_o(instr_pointer_o), .status_word_o(status_word_o),
        .irq_take_o(irq_take_o), .greg_addr_o(greg_addr_o), .vector_addr_o(vector_addr_o)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk_w(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_b(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask

    // Request held until the edge that samples pready high; answer taken there
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        chk_b("pready", 1'b1, pready_o);
        rd  = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        // Let the completing edge settle before callers look at outputs
        @(negedge core_clk_i);
    endtask

    task automatic edges(input int n);
        repeat (n) @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk_w("status", 32'h0030, 32'(status_word_o));
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk_w("reset", i == 6 ? 32'h30 : 32'h0, rd);
        end
    endtask

    task automatic t_regs();
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, 8'(4 * i), 32'hFFFF_A5C0 + 32'(i));
            apb(1'b0, 8'(4 * i), 32'h0);
            chk_w("word", 32'h0000_A5C0 + 32'(i), rd);
        end
        apb(1'b0, 8'h28, 32'h0);
        chk_b("unmapped err", 1'b1, err);
        chk_w("unmapped data", 32'h0, rd);
        apb(1'b1, 8'hFC, 32'h1);
        chk_b("unmapped write err", 1'b1, err);
    endtask

    // op | acc | temp | result | flags H N Z V C
    task automatic t_alu();
        logic [35:0] tv [8];
        logic [4:0]  f;
        tv = '{36'h0_0F_01_10_10, 36'h0_7F_01_80_1A, 36'h0_FF_01_00_15, 36'h1_10_01_0F_10,
               36'h1_00_01_FF_19, 36'h1_80_01_7F_12, 36'h2_81_01_02_11, 36'h3_01_01_00_15};
        apb(1'b1, cdr_pkg::OFS_PROGRAM_STATUS, 32'h0000_0560);
        foreach (tv[i]) begin
            apb(1'b1, cdr_pkg::OFS_ACCUMULATOR, {16'h0, 8'hAB, tv[i][31:24]});
            apb(1'b1, cdr_pkg::OFS_TEMP_ACCUMULATOR, {16'h0, 8'hCD, tv[i][23:16]});
            apb(1'b1, cdr_pkg::OFS_ALU_CTRL, {28'h0, tv[i][35:32]});
            // H in bit 7, N Z V C in bits 3:0 of the flag byte
            f = {status_word_o[7], status_word_o[3:0]};
            chk_w("flags hnz", 32'(tv[i][4:2]), 32'(f[4:2]));
            chk_w("flags vc", 32'(tv[i][1:0]), 32'(f[1:0]));
            apb(1'b0, cdr_pkg::OFS_ACCUMULATOR, 32'h0);
            chk_w("acc", {16'h0, 8'hAB, tv[i][15:8]}, rd);
        end
        chk_w("status kept", 32'h0000_0560, 32'(status_word_o) & 32'h0000_FF70);
    endtask

    task automatic t_irq();
        for (int ie = 0; ie < 2; ie++) begin
            for (int th = 0; th < 4; th++) begin
                apb(1'b1, cdr_pkg::OFS_PROGRAM_STATUS, {24'h0, 1'b0, 1'(ie), 2'(th), 4'h0});
                for (int lv = 0; lv < 8; lv++) begin
                    @(posedge core_clk_i);
                    irq_i <= '{req: 1'(lv >> 2), level: 2'(lv)};
                    edges(1);
                    chk_b("irq", lv >= 4 && ie == 1 && lv % 4 < th, irq_take_o);
                end
            end
        end
        @(posedge core_clk_i);
        irq_i <= '0;
    endtask

    task automatic t_greg();
        int banks [4];
        banks = '{0, 1, 17, 31};
        foreach (banks[b]) begin
            apb(1'b1, cdr_pkg::OFS_PROGRAM_STATUS, {16'h0, 8'(banks[b]), 8'h30});
            for (int r = 0; r < 8; r++) begin
                @(posedge core_clk_i);
                greg_num_i <= 3'(r);
                edges(2);
                chk_w("greg addr", 32'(cdr_pkg::GREG_BASE_DEF + {5'(banks[b]), 3'(r)}),
                    32'(greg_addr_o));
            end
        end
        // Register number override lasts one cycle, then the pin rules again
        apb(1'b1, cdr_pkg::OFS_GREG_SEL, 32'h2);
        edges(1);
        chk_w("greg override", 32'h0000_01FA, 32'(greg_addr_o));
        apb(1'b0, cdr_pkg::OFS_GREG_SEL, 32'h0);
        chk_w("greg read", 32'h0000_01FF, rd);
    endtask

    // Three steps from near the top also prove the wrap
    task automatic t_fetch();
        apb(1'b1, cdr_pkg::OFS_PROGRAM_COUNTER, 32'h0000_FFFE);
        @(posedge core_clk_i);
        fetch_step_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        fetch_step_i <= 1'b0;
        @(negedge core_clk_i);
        chk_w("ip", 32'h0001, 32'(instr_pointer_o));
        apb(1'b0, cdr_pkg::OFS_PROGRAM_COUNTER, 32'h0);
        chk_w("ip read", 32'h0001, rd);
    endtask

    task automatic t_vector();
        int nums [3];
        nums = '{0, 1, 63};
        foreach (nums[k]) begin
            @(posedge core_clk_i);
            vector_num_i <= 6'(nums[k]);
            edges(1);
            chk_w("vector", 32'(cdr_pkg::VEC_TOP_DEF - 16'(2 * nums[k])),
                32'(vector_addr_o));
        end
    endtask

    task automatic t_region();
        logic [17:0] rq [6];
        rq = '{18'h0_0000, 18'h0_007F, 18'h1_0080, 18'h1_3FFF, 18'h2_4000, 18'h2_FFFF};
        foreach (rq[k]) begin
            apb(1'b1, cdr_pkg::OFS_REGION_QUERY, {16'h0, rq[k][15:0]});
            apb(1'b0, cdr_pkg::OFS_REGION_QUERY, 32'h0);
            chk_w("region", {14'h0, rq[k]}, rd);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge core_clk_i);
        bad_count++;
        report_and_stop();
    end

    initial begin
        rst_i        = 1'b1;
        psel_i       = 1'b0;
        penable_i    = 1'b0;
        pwrite_i     = 1'b0;
        paddr_i      = 8'h00;
        pwdata_i     = 32'h0;
        fetch_step_i = 1'b0;
        vector_num_i = 6'h00;
        irq_i        = '0;
        greg_num_i   = 3'h0;
        bad_count    = 0;
        check_count  = 0;
        repeat (10) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(negedge core_clk_i);
        t_reset();
        t_regs();
        t_alu();
        t_irq();
        t_greg();
        t_fetch();
        t_vector();
        t_region();
        report_and_stop();
    end
endmodule

`default_nettype wire

// >>> src/cdr_pkg.sv
// Constants, register map and carriers for the core dedicated register file
package cdr_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned WORD_W   = 16;
    localparam int unsigned BYTE_W   = 8;
    localparam int unsigned APB_AW   = 8;
    localparam int unsigned APB_DW   = 32;
    localparam int unsigned BANK_W   = 5;
    localparam int unsigned REGNUM_W = 3;
    localparam int unsigned VECNUM_W = 6;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [APB_AW-1:0] OFS_PROGRAM_COUNTER  = 8'h00;
    localparam logic [APB_AW-1:0] OFS_ACCUMULATOR      = 8'h04;
    localparam logic [APB_AW-1:0] OFS_TEMP_ACCUMULATOR = 8'h08;
    localparam logic [APB_AW-1:0] OFS_INDEX_REGISTER   = 8'h0C;
    localparam logic [APB_AW-1:0] OFS_EXTRA_POINTER    = 8'h10;
    localparam logic [APB_AW-1:0] OFS_STACK_POINTER    = 8'h14;
    localparam logic [APB_AW-1:0] OFS_PROGRAM_STATUS   = 8'h18;
    localparam logic [APB_AW-1:0] OFS_ALU_CTRL         = 8'h1C;
    localparam logic [APB_AW-1:0] OFS_GREG_SEL         = 8'h20;
    localparam logic [APB_AW-1:0] OFS_REGION_QUERY     = 8'h24;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned PS_BANK_LSB  = 8;
    localparam int unsigned ALU_OP_LSB   = 0;
    localparam int unsigned REGION_LSB   = 16;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [WORD_W-1:0] RST_WORD      = 16'h0000;
    localparam logic [BYTE_W-1:0] RST_BANK      = 8'h00;
    localparam logic [1:0]        RST_THRESHOLD = 2'h3;
    localparam logic [APB_DW-1:0] RD_ZERO       = 32'h0000_0000;

    // ------------------------------------------------------------
    // Memory map
    // ------------------------------------------------------------
    localparam logic [WORD_W-1:0] IO_TOP_DEF    = 16'h007F;
    localparam logic [WORD_W-1:0] PROG_BASE_DEF = 16'h4000;
    localparam logic [WORD_W-1:0] GREG_BASE_DEF = 16'h0100;
    localparam logic [WORD_W-1:0] VEC_TOP_DEF   = 16'hFFFE;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CDR_OP_ADD = 2'h0,
        CDR_OP_SUB = 2'h1,
        CDR_OP_SHL = 2'h2,
        CDR_OP_SHR = 2'h3
    } cdr_alu_op_e;

    typedef enum logic [1:0] {
        CDR_REG_IO   = 2'h0,
        CDR_REG_DATA = 2'h1,
        CDR_REG_PROG = 2'h2
    } cdr_region_e;

    // Flag byte layout, most significant first
    typedef struct packed {
        logic       half_carry;
        logic       irq_enable;
        logic [1:0] priority_threshold;
        logic       negative;
        logic       zero;
        logic       overflow;
        logic       carry;
    } cdr_flag_byte_s;

    typedef struct packed {
        logic [BYTE_W-1:0] bank_select;
        cdr_flag_byte_s    flag_byte;
    } cdr_status_word_s;

    typedef struct packed {
        logic       req;
        logic [1:0] level;
    } cdr_irq_s;

endpackage

// >>> src/cdr_regfile.sv
// Core dedicated registers, flag logic and bank address mapping with an APB slave
`timescale 1ns/1ps
`default_nettype none

module cdr_regfile #(
    parameter logic [15:0] IO_TOP    = cdr_pkg::IO_TOP_DEF,
    parameter logic [15:0] PROG_BASE = cdr_pkg::PROG_BASE_DEF,
    parameter logic [15:0] GREG_BASE = cdr_pkg::GREG_BASE_DEF,
    parameter logic [15:0] VEC_TOP   = cdr_pkg::VEC_TOP_DEF
) (
    // Clock and reset
    input  wire logic                                   core_clk_i,
    input  wire logic                                   rst_i,
    // APB slave
    input  wire logic                                   psel_i,
    input  wire logic                                   penable_i,
    input  wire logic                                   pwrite_i,
    input  wire logic [cdr_pkg::APB_AW-1:0]             paddr_i,
    input  wire logic [cdr_pkg::APB_DW-1:0]             pwdata_i,
    output var  logic [cdr_pkg::APB_DW-1:0]             prdata_o,
    output var  logic                                   pready_o,
    output var  logic                                   pslverr_o,
    // Core side
    input  wire logic                                   fetch_step_i,
    input  wire logic [cdr_pkg::VECNUM_W-1:0]           vector_num_i,
    input  wire cdr_pkg::cdr_irq_s                      irq_i,
    input  wire logic [cdr_pkg::REGNUM_W-1:0]           greg_num_i,
    output var  logic [cdr_pkg::WORD_W-1:0]             instr_pointer_o,
    output var  cdr_pkg::cdr_status_word_s              status_word_o,
    output var  logic                                   irq_take_o,
    output var  logic [cdr_pkg::WORD_W-1:0]             greg_addr_o,
    output var  logic [cdr_pkg::WORD_W-1:0]             vector_addr_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [cdr_pkg::WORD_W-1:0]   program_counter;
    logic [cdr_pkg::WORD_W-1:0]   accumulator;
    logic [cdr_pkg::WORD_W-1:0]   temp_accumulator;
    logic [cdr_pkg::WORD_W-1:0]   index_register;
    logic [cdr_pkg::WORD_W-1:0]   extra_pointer;
    logic [cdr_pkg::WORD_W-1:0]   stack_pointer;
    cdr_pkg::cdr_status_word_s    program_status;
    logic [cdr_pkg::WORD_W-1:0]   region_addr;
    logic [cdr_pkg::REGNUM_W-1:0] greg_sel;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic setup_phase = psel_i & ~penable_i;
    wire logic access_done = psel_i & penable_i & pready_o;
    wire logic wr_done     = access_done & pwrite_i;

    wire logic hit_pc   = (paddr_i == cdr_pkg::OFS_PROGRAM_COUNTER);
    wire logic hit_acc  = (paddr_i == cdr_pkg::OFS_ACCUMULATOR);
    wire logic hit_tmp  = (paddr_i == cdr_pkg::OFS_TEMP_ACCUMULATOR);
    wire logic hit_idx  = (paddr_i == cdr_pkg::OFS_INDEX_REGISTER);
    wire logic hit_ep   = (paddr_i == cdr_pkg::OFS_EXTRA_POINTER);
    wire logic hit_sp   = (paddr_i == cdr_pkg::OFS_STACK_POINTER);
    wire logic hit_ps   = (paddr_i == cdr_pkg::OFS_PROGRAM_STATUS);
    wire logic hit_alu  = (paddr_i == cdr_pkg::OFS_ALU_CTRL);
    wire logic hit_greg = (paddr_i == cdr_pkg::OFS_GREG_SEL);
    wire logic hit_rgn  = (paddr_i == cdr_pkg::OFS_REGION_QUERY);
    wire logic hit_any  = hit_pc | hit_acc | hit_tmp | hit_idx | hit_ep | hit_sp
                        | hit_ps | hit_alu | hit_greg | hit_rgn;

    // ------------------------------------------------------------
    // Byte arithmetic on the low bytes of both accumulators
    // ------------------------------------------------------------
    wire cdr_pkg::cdr_alu_op_e alu_op =
        cdr_pkg::cdr_alu_op_e'(pwdata_i[cdr_pkg::ALU_OP_LSB +: 2]);
    wire logic [7:0] opa = accumulator[7:0];
    wire logic [7:0] opb = temp_accumulator[7:0];

    wire logic [8:0] add_full = {1'b0, opa} + {1'b0, opb};
    wire logic [8:0] sub_full = {1'b0, opa} - {1'b0, opb};
    wire logic [4:0] add_nib  = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
    wire logic [4:0] sub_nib  = {1'b0, opa[3:0]} - {1'b0, opb[3:0]};

    logic [7:0] alu_res;
    logic       alu_c;
    logic       alu_h;
    logic       alu_v;

    always_comb begin
        alu_res = add_full[7:0];
        alu_c   = add_full[8];
        alu_h   = program_status.flag_byte.half_carry;
        alu_v   = 1'b0;
        unique case (alu_op)
            cdr_pkg::CDR_OP_ADD: begin
                alu_res = add_full[7:0];
                alu_c   = add_full[8];
                alu_h   = add_nib[4];
                alu_v   = (opa[7] == opb[7]) & (add_full[7] != opa[7]);
            end
            cdr_pkg::CDR_OP_SUB: begin
                alu_res = sub_full[7:0];
                alu_c   = sub_full[8];
                alu_h   = sub_nib[4];
                alu_v   = (opa[7] != opb[7]) & (sub_full[7] != opa[7]);
            end
            cdr_pkg::CDR_OP_SHL: begin
                alu_res = {opa[6:0], 1'b0};
                alu_c   = opa[7];
            end
            cdr_pkg::CDR_OP_SHR: begin
                alu_res = {1'b0, opa[7:1]};
                alu_c   = opa[0];
            end
        endcase
    end

    cdr_pkg::cdr_flag_byte_s alu_flags;
    always_comb begin
        alu_flags                    = program_status.flag_byte;
        alu_flags.half_carry         = alu_h;
        alu_flags.negative           = alu_res[7];
        alu_flags.zero               = (alu_res == 8'h00);
        alu_flags.overflow           = alu_v;
        alu_flags.carry              = alu_c;
    end

    wire logic alu_fire = wr_done & hit_alu;

    // ------------------------------------------------------------
    // Map helpers
    // ------------------------------------------------------------
    // Only 32 banks exist; upper bank bits are ignored by the mapping
    wire logic [cdr_pkg::BANK_W-1:0] bank =
        program_status.bank_select[cdr_pkg::BANK_W-1:0];
    wire logic [cdr_pkg::WORD_W-1:0] greg_off =
        {8'h00, bank, greg_sel};
    wire logic [cdr_pkg::WORD_W-1:0] greg_addr = GREG_BASE + greg_off;

    wire cdr_pkg::cdr_region_e region =
        (region_addr <= IO_TOP)   ? cdr_pkg::CDR_REG_IO   :
        (region_addr <  PROG_BASE) ? cdr_pkg::CDR_REG_DATA :
                                    cdr_pkg::CDR_REG_PROG;

    // Two bytes per vector, counted down from the top word
    wire logic [cdr_pkg::WORD_W-1:0] vec_off =
        {9'h000, vector_num_i, 1'b0};
    wire logic [cdr_pkg::WORD_W-1:0] vector_addr = VEC_TOP - vec_off;

    // Lower level number is stronger
    wire logic irq_ok = irq_i.req & program_status.flag_byte.irq_enable
                      & (irq_i.level < program_status.flag_byte.priority_threshold);

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [cdr_pkg::APB_DW-1:0] rd_mux;
    always_comb begin
        rd_mux = cdr_pkg::RD_ZERO;
        if (hit_pc) begin
            rd_mux[15:0] = program_counter;
        end
        if (hit_acc) begin
            rd_mux[15:0] = accumulator;
        end
        if (hit_tmp) begin
            rd_mux[15:0] = temp_accumulator;
        end
        if (hit_idx) begin
            rd_mux[15:0] = index_register;
        end
        if (hit_ep) begin
            rd_mux[15:0] = extra_pointer;
        end
        if (hit_sp) begin
            rd_mux[15:0] = stack_pointer;
        end
        if (hit_ps) begin
            rd_mux[15:0] = program_status;
        end
        if (hit_greg) begin
            rd_mux[15:0] = greg_addr;
        end
        if (hit_rgn) begin
            rd_mux[15:0]                       = region_addr;
            rd_mux[cdr_pkg::REGION_LSB +: 2]   = region;
        end
    end

    // ------------------------------------------------------------
    // APB handshake: one wait-free access phase
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= cdr_pkg::RD_ZERO;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= setup_phase;
            prdata_o  <= (setup_phase & ~pwrite_i) ? rd_mux : cdr_pkg::RD_ZERO;
            pslverr_o <= setup_phase & ~hit_any;
        end
    end

    // ------------------------------------------------------------
    // Dedicated registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            program_counter <= cdr_pkg::RST_WORD;
        end else if (wr_done & hit_pc) begin
            program_counter <= pwdata_i[15:0];
        end else if (fetch_step_i) begin
            program_counter <= program_counter + 16'h0001;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            accumulator <= cdr_pkg::RST_WORD;
        end else if (wr_done & hit_acc) begin
            accumulator <= pwdata_i[15:0];
        end else if (alu_fire) begin
            accumulator[7:0] <= alu_res;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            temp_accumulator <= cdr_pkg::RST_WORD;
            index_register   <= cdr_pkg::RST_WORD;
            extra_pointer    <= cdr_pkg::RST_WORD;
            stack_pointer    <= cdr_pkg::RST_WORD;
        end else begin
            if (wr_done & hit_tmp) begin
                temp_accumulator <= pwdata_i[15:0];
            end
            if (wr_done & hit_idx) begin
                index_register <= pwdata_i[15:0];
            end
            if (wr_done & hit_ep) begin
                extra_pointer <= pwdata_i[15:0];
            end
            if (wr_done & hit_sp) begin
                stack_pointer <= pwdata_i[15:0];
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            program_status.bank_select                  <= cdr_pkg::RST_BANK;
            program_status.flag_byte                    <= '0;
            program_status.flag_byte.priority_threshold <= cdr_pkg::RST_THRESHOLD;
        end else if (wr_done & hit_ps) begin
            program_status <= pwdata_i[15:0];
        end else if (alu_fire) begin
            program_status.flag_byte <= alu_flags;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            greg_sel    <= '0;
            region_addr <= cdr_pkg::RST_WORD;
        end else begin
            if (wr_done & hit_greg) begin
                greg_sel <= pwdata_i[cdr_pkg::REGNUM_W-1:0];
            end else begin
                greg_sel <= greg_num_i;
            end
            if (wr_done & hit_rgn) begin
                region_addr <= pwdata_i[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Registered core outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_take_o    <= 1'b0;
            greg_addr_o   <= cdr_pkg::RST_WORD;
            vector_addr_o <= cdr_pkg::RST_WORD;
        end else begin
            irq_take_o    <= irq_ok;
            greg_addr_o   <= greg_addr;
            vector_addr_o <= vector_addr;
        end
    end

    assign instr_pointer_o = program_counter;
    assign status_word_o   = program_status;

endmodule

`default_nettype wire
